// *** verilog/pcgr_ctl.sv ***
// peripheral clock gate and block reset control registers with the gates
// they steer; assumes a single-cycle register port on clk_in, and free-running
// high-speed and low-speed clocks that are gated here for each peripheral
//
// Behaviour
// R1 - gate bit 1 stops clocks, 0 delivers
// R2 - all gate bits reset to 0
// R3 - reset bit 1 holds peripheral in reset
// R4 - all block reset bits reset to 0
// R5 - gating covers system, high and low clocks
// R6 - byte and even-address word access, zero reset
// R7 - second gate register at 0xF072/0xF073
// R8 - fourth gate register at 0xF076/0xF077
// R9 - second reset register at 0xF07A/0xF07B
// R10 - gate 2: timers bits 0-5, bus 12
// R11 - gate 3: muldiv 13, serial 5 and 4
// R12 - gate 4: amp, comparators, converters, adc
// R13 - first registers: bit 0 timer16 only
// R14 - reset 2 mirrors gate 2 layout
// R15 - reset 3: muldiv 13, serial 5, 4
// R16 - reset 4: amp, comparators, converters, adc
// R17 - first reset register at 0xF078/0xF079
// R18 - reserved bits read 0, ignore writes
// R19 - clock gates never glitch or truncate pulses
//
// Local design decision: the strobed register port.

`timescale 1ns/100ps

module pcgr_ctl #(
   parameter int NUM_PERIPH = pcgr_pkg::PCGR_NUM_PERIPH
) (
   // clocks and reset
   input wire logic clk_in,
   input wire logic hs_clk_in,
   input wire logic ls_clk_in,
   input wire logic resetn_in,
   // register port
   input wire pcgr_pkg::pcgr_bus_req_t bus_req_in,
   output logic [15:0] bus_rdata_out,
   // per-peripheral controls
   output logic [NUM_PERIPH-1:0] clk_stop_out,
   output logic [NUM_PERIPH-1:0] rst_hold_out,
   // gated clocks
   output pcgr_pkg::pcgr_gclk_t gclk_out
);

   // ==================================================================
   // elaboration check
   if (NUM_PERIPH != pcgr_pkg::PCGR_NUM_PERIPH) begin : g_bad_count
      $error("peripheral count must match the fixed register layout");
   end

   pcgr_pkg::pcgr_state_t state_q;
   pcgr_pkg::pcgr_state_t state_d;

   logic in_range;
   logic [2:0] reg_idx;
   logic hi_byte;
   logic access_ok;
   logic [15:0] wr_mask;
   logic [15:0] cur_reg;
   logic [15:0] new_reg;

   // ==================================================================
   // address decode
   assign in_range = bus_req_in.addr[15:4] == pcgr_pkg::PCGR_GATE0_ADDR[15:4];
   assign reg_idx = bus_req_in.addr[3:1];
   assign hi_byte = bus_req_in.addr[0];
   // a word access must name the even address; odd-address words are dropped
   assign access_ok = in_range && !(bus_req_in.word && hi_byte); // R6

   // writable bits per register; the two banks share one layout
   function automatic logic [15:0] reg_mask(input logic [2:0] idx);
      logic [15:0] m;
      m = 16'h0000;
      if (idx == pcgr_pkg::PCGR_IDX_GATE0 || idx == pcgr_pkg::PCGR_IDX_HOLD0) begin
         m = pcgr_pkg::PCGR_MASK_0; // R13
      end else if (idx == pcgr_pkg::PCGR_IDX_GATE1 || idx == pcgr_pkg::PCGR_IDX_HOLD1) begin
         m = pcgr_pkg::PCGR_MASK_1; // R10
      end else if (idx == pcgr_pkg::PCGR_IDX_GATE2 || idx == pcgr_pkg::PCGR_IDX_HOLD2) begin
         m = pcgr_pkg::PCGR_MASK_2; // R11
      end else if (idx == pcgr_pkg::PCGR_IDX_GATE3 || idx == pcgr_pkg::PCGR_IDX_HOLD3) begin
         m = pcgr_pkg::PCGR_MASK_3; // R12
      end
      return m;
   endfunction

   // ==================================================================
   // next state: register writes and read data
   always_comb begin
      state_d = state_q;
      wr_mask = reg_mask(reg_idx);
      cur_reg = state_q.regs[reg_idx];
      new_reg = cur_reg;
      state_d.rdata = 16'h0000;

      if (bus_req_in.wr && access_ok) begin
         if (bus_req_in.word) begin
            new_reg = bus_req_in.wdata; // R6
         end else if (hi_byte) begin
            new_reg = {bus_req_in.wdata[7:0], cur_reg[7:0]}; // R6
         end else begin
            new_reg = {cur_reg[15:8], bus_req_in.wdata[7:0]}; // R6
         end
         // reserved positions never store a one
         state_d.regs[reg_idx] = new_reg & wr_mask; // R18
      end

      // a byte read returns its byte in the low lane with zeros above
      if (bus_req_in.rd && access_ok) begin
         if (bus_req_in.word) begin
            state_d.rdata = cur_reg & wr_mask; // R18
         end else if (hi_byte) begin
            state_d.rdata = {8'h00, cur_reg[15:8] & wr_mask[15:8]};
         end else begin
            state_d.rdata = {8'h00, cur_reg[7:0] & wr_mask[7:0]};
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < pcgr_pkg::PCGR_NUM_REGS; i++) begin
            state_q.regs[i] <= pcgr_pkg::PCGR_REG_RESET; // R2 R4 R6
         end
         state_q.rdata <= 16'h0000;
      end else begin
         state_q <= state_d;
      end
   end

   assign bus_rdata_out = state_q.rdata;

   // ==================================================================
   // named views of the control bits
   logic [15:0] gate0_q;
   logic [15:0] gate1_q;
   logic [15:0] gate2_q;
   logic [15:0] gate3_q;
   logic [15:0] hold0_q;
   logic [15:0] hold1_q;
   logic [15:0] hold2_q;
   logic [15:0] hold3_q;

   assign gate0_q = state_q.regs[pcgr_pkg::PCGR_IDX_GATE0];
   assign gate1_q = state_q.regs[pcgr_pkg::PCGR_IDX_GATE1]; // R7
   assign gate2_q = state_q.regs[pcgr_pkg::PCGR_IDX_GATE2];
   assign gate3_q = state_q.regs[pcgr_pkg::PCGR_IDX_GATE3]; // R8
   assign hold0_q = state_q.regs[pcgr_pkg::PCGR_IDX_HOLD0]; // R17
   assign hold1_q = state_q.regs[pcgr_pkg::PCGR_IDX_HOLD1]; // R9
   assign hold2_q = state_q.regs[pcgr_pkg::PCGR_IDX_HOLD2];
   assign hold3_q = state_q.regs[pcgr_pkg::PCGR_IDX_HOLD3];

   logic timer16_0_clk_stop;
   logic [pcgr_pkg::PCGR_NUM_OPTIMERS-1:0] optimer_clk_stop;
   logic twi_unit0_clk_stop;
   logic serial0_clk_stop;
   logic serial1_clk_stop;
   logic muldiv_clk_stop;
   logic sar_adc_clk_stop;
   logic dac0_clk_stop;
   logic dac1_clk_stop;
   logic comparator0_clk_stop;
   logic comparator1_clk_stop;
   logic comparator2_clk_stop;
   logic gain_amp_clk_stop;

   assign timer16_0_clk_stop = gate0_q[pcgr_pkg::PCGR_TIMER16_0_BIT]; // R13
   assign optimer_clk_stop =
      gate1_q[pcgr_pkg::PCGR_OPTIMER0_BIT +: pcgr_pkg::PCGR_NUM_OPTIMERS]; // R10
   assign twi_unit0_clk_stop = gate1_q[pcgr_pkg::PCGR_TWI0_BIT]; // R10
   assign serial0_clk_stop = gate2_q[pcgr_pkg::PCGR_SERIAL0_BIT]; // R11
   assign serial1_clk_stop = gate2_q[pcgr_pkg::PCGR_SERIAL1_BIT]; // R11
   assign muldiv_clk_stop = gate2_q[pcgr_pkg::PCGR_MULDIV_BIT]; // R11
   assign sar_adc_clk_stop = gate3_q[pcgr_pkg::PCGR_SAR_ADC_BIT]; // R12
   assign dac0_clk_stop = gate3_q[pcgr_pkg::PCGR_DAC0_BIT]; // R12
   assign dac1_clk_stop = gate3_q[pcgr_pkg::PCGR_DAC1_BIT]; // R12
   assign comparator0_clk_stop = gate3_q[pcgr_pkg::PCGR_CMP0_BIT]; // R12
   assign comparator1_clk_stop = gate3_q[pcgr_pkg::PCGR_CMP1_BIT]; // R12
   assign comparator2_clk_stop = gate3_q[pcgr_pkg::PCGR_CMP2_BIT]; // R12
   assign gain_amp_clk_stop = gate3_q[pcgr_pkg::PCGR_GAIN_AMP_BIT]; // R12

   logic timer16_0_rst_hold;
   logic [pcgr_pkg::PCGR_NUM_OPTIMERS-1:0] optimer_rst_hold;
   logic twi_unit0_rst_hold;
   logic serial0_rst_hold;
   logic serial1_rst_hold;
   logic muldiv_rst_hold;
   logic sar_adc_rst_hold;
   logic dac0_rst_hold;
   logic dac1_rst_hold;
   logic comparator0_rst_hold;
   logic comparator1_rst_hold;
   logic comparator2_rst_hold;
   logic gain_amp_rst_hold;

   assign timer16_0_rst_hold = hold0_q[pcgr_pkg::PCGR_TIMER16_0_BIT]; // R13
   assign optimer_rst_hold =
      hold1_q[pcgr_pkg::PCGR_OPTIMER0_BIT +: pcgr_pkg::PCGR_NUM_OPTIMERS]; // R14
   assign twi_unit0_rst_hold = hold1_q[pcgr_pkg::PCGR_TWI0_BIT]; // R14
   assign serial0_rst_hold = hold2_q[pcgr_pkg::PCGR_SERIAL0_BIT]; // R15
   assign serial1_rst_hold = hold2_q[pcgr_pkg::PCGR_SERIAL1_BIT]; // R15
   assign muldiv_rst_hold = hold2_q[pcgr_pkg::PCGR_MULDIV_BIT]; // R15
   assign sar_adc_rst_hold = hold3_q[pcgr_pkg::PCGR_SAR_ADC_BIT]; // R16
   assign dac0_rst_hold = hold3_q[pcgr_pkg::PCGR_DAC0_BIT]; // R16
   assign dac1_rst_hold = hold3_q[pcgr_pkg::PCGR_DAC1_BIT]; // R16
   assign comparator0_rst_hold = hold3_q[pcgr_pkg::PCGR_CMP0_BIT]; // R16
   assign comparator1_rst_hold = hold3_q[pcgr_pkg::PCGR_CMP1_BIT]; // R16
   assign comparator2_rst_hold = hold3_q[pcgr_pkg::PCGR_CMP2_BIT]; // R16
   assign gain_amp_rst_hold = hold3_q[pcgr_pkg::PCGR_GAIN_AMP_BIT]; // R16

   // ==================================================================
   // output vectors, one slot per peripheral
   always_comb begin
      clk_stop_out = '0;
      clk_stop_out[pcgr_pkg::PCGR_P_TIMER16_0] = timer16_0_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_OPTIMER0 +: pcgr_pkg::PCGR_NUM_OPTIMERS] = optimer_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_TWI0] = twi_unit0_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_SERIAL0] = serial0_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_SERIAL1] = serial1_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_MULDIV] = muldiv_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_SAR_ADC] = sar_adc_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_DAC0] = dac0_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_DAC1] = dac1_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_CMP0] = comparator0_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_CMP1] = comparator1_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_CMP2] = comparator2_clk_stop;
      clk_stop_out[pcgr_pkg::PCGR_P_GAIN_AMP] = gain_amp_clk_stop;
   end

   // a one keeps the peripheral's reset asserted; zero lets it run
   always_comb begin
      rst_hold_out = '0;
      rst_hold_out[pcgr_pkg::PCGR_P_TIMER16_0] = timer16_0_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_OPTIMER0 +: pcgr_pkg::PCGR_NUM_OPTIMERS] = optimer_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_TWI0] = twi_unit0_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_SERIAL0] = serial0_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_SERIAL1] = serial1_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_MULDIV] = muldiv_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_SAR_ADC] = sar_adc_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_DAC0] = dac0_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_DAC1] = dac1_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_CMP0] = comparator0_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_CMP1] = comparator1_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_CMP2] = comparator2_rst_hold; // R3
      rst_hold_out[pcgr_pkg::PCGR_P_GAIN_AMP] = gain_amp_rst_hold; // R3
   end

   // ==================================================================
   // clock gates: three clocks per peripheral
   // each gate resynchronises the stop bit into its own clock, so a stop
   // takes effect a few edges of that clock after the register write; on
   // the low-speed clock this delay is long compared with the bus clock
   for (genvar p = 0; p < NUM_PERIPH; p++) begin : g_gate
      pcgr_clk_gate u_sys_gate (
         .clk_in(clk_in),
         .resetn_in(resetn_in),
         .stop_in(clk_stop_out[p]), // R1 R5
         .gclk_out(gclk_out.sys[p]) // R19
      );
      pcgr_clk_gate u_hs_gate (
         .clk_in(hs_clk_in),
         .resetn_in(resetn_in),
         .stop_in(clk_stop_out[p]), // R1 R5
         .gclk_out(gclk_out.hs[p]) // R19
      );
      pcgr_clk_gate u_ls_gate (
         .clk_in(ls_clk_in),
         .resetn_in(resetn_in),
         .stop_in(clk_stop_out[p]), // R1 R5
         .gclk_out(gclk_out.ls[p]) // R19
      );
   end

endmodule

// *** shared/pcgr_pkg.sv ***
// peripheral clock gate and block reset control: shared constants and types
// assumes a 16-bit register space reached by byte or word accesses at 0xF070..0xF07F

package pcgr_pkg;

   // ==================================================================
   // register map
   localparam logic [15:0] PCGR_GATE0_ADDR = 16'hF070;
   localparam logic [15:0] PCGR_GATE1_ADDR = 16'hF072;
   localparam logic [15:0] PCGR_GATE2_ADDR = 16'hF074;
   localparam logic [15:0] PCGR_GATE3_ADDR = 16'hF076;
   localparam logic [15:0] PCGR_HOLD0_ADDR = 16'hF078;
   localparam logic [15:0] PCGR_HOLD1_ADDR = 16'hF07A;
   localparam logic [15:0] PCGR_HOLD2_ADDR = 16'hF07C;
   localparam logic [15:0] PCGR_HOLD3_ADDR = 16'hF07E;

   localparam int PCGR_NUM_REGS = 8;
   localparam logic [2:0] PCGR_IDX_GATE0 = 3'h0;
   localparam logic [2:0] PCGR_IDX_GATE1 = 3'h1;
   localparam logic [2:0] PCGR_IDX_GATE2 = 3'h2;
   localparam logic [2:0] PCGR_IDX_GATE3 = 3'h3;
   localparam logic [2:0] PCGR_IDX_HOLD0 = 3'h4;
   localparam logic [2:0] PCGR_IDX_HOLD1 = 3'h5;
   localparam logic [2:0] PCGR_IDX_HOLD2 = 3'h6;
   localparam logic [2:0] PCGR_IDX_HOLD3 = 3'h7;

   localparam logic [15:0] PCGR_REG_RESET = 16'h0000;

   // writable bits of each register pair; the rest are reserved
   localparam logic [15:0] PCGR_MASK_0 = 16'h0001;
   localparam logic [15:0] PCGR_MASK_1 = 16'h103F;
   localparam logic [15:0] PCGR_MASK_2 = 16'h2030;
   localparam logic [15:0] PCGR_MASK_3 = 16'h007F;

   // ==================================================================
   // field positions
   localparam int PCGR_TIMER16_0_BIT = 0;
   localparam int PCGR_OPTIMER0_BIT = 0;
   localparam int PCGR_NUM_OPTIMERS = 6;
   localparam int PCGR_TWI0_BIT = 12;
   localparam int PCGR_SERIAL0_BIT = 4;
   localparam int PCGR_SERIAL1_BIT = 5;
   localparam int PCGR_MULDIV_BIT = 13;
   localparam int PCGR_SAR_ADC_BIT = 0;
   localparam int PCGR_DAC0_BIT = 1;
   localparam int PCGR_DAC1_BIT = 2;
   localparam int PCGR_CMP0_BIT = 3;
   localparam int PCGR_CMP1_BIT = 4;
   localparam int PCGR_CMP2_BIT = 5;
   localparam int PCGR_GAIN_AMP_BIT = 6;

   // ==================================================================
   // peripheral slot numbers on the output vectors
   localparam int PCGR_NUM_PERIPH = 18;
   localparam int PCGR_P_TIMER16_0 = 0;
   localparam int PCGR_P_OPTIMER0 = 1;
   localparam int PCGR_P_TWI0 = 7;
   localparam int PCGR_P_SERIAL0 = 8;
   localparam int PCGR_P_SERIAL1 = 9;
   localparam int PCGR_P_MULDIV = 10;
   localparam int PCGR_P_SAR_ADC = 11;
   localparam int PCGR_P_DAC0 = 12;
   localparam int PCGR_P_DAC1 = 13;
   localparam int PCGR_P_CMP0 = 14;
   localparam int PCGR_P_CMP1 = 15;
   localparam int PCGR_P_CMP2 = 16;
   localparam int PCGR_P_GAIN_AMP = 17;

   // ==================================================================
   // carriers
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic word;
      logic wr;
      logic rd;
   } pcgr_bus_req_t;

   typedef struct packed {
      logic [PCGR_NUM_PERIPH-1:0] sys;
      logic [PCGR_NUM_PERIPH-1:0] hs;
      logic [PCGR_NUM_PERIPH-1:0] ls;
   } pcgr_gclk_t;

   typedef struct packed {
      logic [PCGR_NUM_REGS-1:0][15:0] regs;
      logic [15:0] rdata;
   } pcgr_state_t;

   typedef struct packed {
      logic meta;
      logic sync;
   } pcgr_sync_t;

endpackage

// *** verilog/pcgr_clk_gate.sv ***
// glitch-free gate for one clock to one peripheral
// assumes stop_in may change at any time relative to clk_in; resetn_in is held
// for at least three edges of clk_in

`timescale 1ns/100ps

module pcgr_clk_gate (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // control
   input wire logic stop_in,
   // gated clock
   output logic gclk_out
);

   pcgr_pkg::pcgr_sync_t state_q;
   pcgr_pkg::pcgr_sync_t state_d;
   logic enable_l;

   // ==================================================================
   // resynchronise the stop request into this clock
   always_comb begin
      state_d.meta = stop_in;
      state_d.sync = state_q.meta;
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // ==================================================================
   // enable changes only while the clock is low, so no pulse is ever cut
   always_latch begin
      if (!clk_in) begin
         enable_l = ~state_q.sync;
      end
   end

   assign gclk_out = clk_in & enable_l;

endmodule

// *** tb/pcgr_ctl_asserts.sv ***
// port checker for the clock gate and block reset control
// assumes it is bound to pcgr_ctl; bus strobes are single-cycle pulses
`timescale 1ns/100ps
module pcgr_ctl_chk #(
   parameter int NUM_PERIPH = pcgr_pkg::PCGR_NUM_PERIPH
) (
   // clocks and reset
   input wire logic clk_in,
   input wire logic hs_clk_in,
   input wire logic ls_clk_in,
   input wire logic resetn_in,
   // register port
   input wire pcgr_pkg::pcgr_bus_req_t bus_req_in,
   input wire logic [15:0] bus_rdata_out,
   // controls and gated clocks
   input wire logic [NUM_PERIPH-1:0] clk_stop_out,
   input wire logic [NUM_PERIPH-1:0] rst_hold_out,
   input wire pcgr_pkg::pcgr_gclk_t gclk_out
);
   // ==========================================================
   // helper: cycles the first slot has been stopped, saturating
   logic [3:0] stop_cnt_q;
   always_ff @(posedge clk_in) begin
      if (!resetn_in || !clk_stop_out[0]) stop_cnt_q <= 4'h0;
      else if (stop_cnt_q != 4'hF) stop_cnt_q <= stop_cnt_q + 4'h1;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // ==========================================================
   // access sequences
   sequence s_wr(a, w);
      bus_req_in.wr && bus_req_in.word == w && bus_req_in.addr == a;
   endsequence
   sequence s_rd(a, w);
      bus_req_in.rd && bus_req_in.word == w && bus_req_in.addr == a;
   endsequence
   // ==========================================================
   // assertions
   a_rdata_idle: assert property (!$past(bus_req_in.rd) |-> bus_rdata_out == 16'h0000)
      else $error("read data not zero outside a read answer");
   a_reset_clear: assert property ($rose(resetn_in) |-> clk_stop_out == '0 && rst_hold_out == '0)
      else $error("controls not clear after reset");
   a_gate1_word: assert property (s_wr(16'hF072, 1'b1) |=>
      clk_stop_out[7:1] == {$past(bus_req_in.wdata[12]), $past(bus_req_in.wdata[5:0])})
      else $error("second gate word write not applied");
   a_hold1_word: assert property (s_wr(16'hF07A, 1'b1) |=>
      rst_hold_out[7:1] == {$past(bus_req_in.wdata[12]), $past(bus_req_in.wdata[5:0])})
      else $error("second reset word write not applied");
   a_gate3_byte: assert property (s_wr(16'hF076, 1'b0) |=>
      clk_stop_out[17:11] == $past(bus_req_in.wdata[6:0]))
      else $error("fourth gate byte write not applied");
   a_hold2_high: assert property (s_wr(16'hF07D, 1'b0) |=> rst_hold_out[10] == $past(bus_req_in.wdata[5]))
      else $error("muldiv reset byte write not applied");
   a_ctl_steady: assert property (!bus_req_in.wr |=> $stable(clk_stop_out) && $stable(rst_hold_out))
      else $error("controls changed without a write");
   a_gate2_read: assert property (s_rd(16'hF075, 1'b0) |=> bus_rdata_out == {10'h000, clk_stop_out[10], 5'h00})
      else $error("third gate high byte read wrong");
   a_hold3_read: assert property (s_rd(16'hF07E, 1'b1) |=> bus_rdata_out == {9'h000, rst_hold_out[17:11]})
      else $error("fourth reset word read wrong");
   // a stopped clock may still finish its pulse, but must be gone by the fourth cycle
   a_gclk_stop: assert property (@(posedge gclk_out.sys[0]) disable iff (!resetn_in)
      stop_cnt_q < 4'h4)
      else $error("gated clock pulses while stopped");
endmodule

bind pcgr_ctl pcgr_ctl_chk #(.NUM_PERIPH(NUM_PERIPH)) u_pcgr_ctl_chk (
   .clk_in(clk_in), .hs_clk_in(hs_clk_in), .ls_clk_in(ls_clk_in), .resetn_in(resetn_in),
   .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out), .clk_stop_out(clk_stop_out),
   .rst_hold_out(rst_hold_out), .gclk_out(gclk_out));

// *** tb/pcgr_periph_model.sv ***
// peripheral side: counts clock pulses each peripheral receives
// assumes the gated clocks idle low when stopped
`timescale 1ns/100ps
module pcgr_periph_model #(
   parameter int NUM_PERIPH = pcgr_pkg::PCGR_NUM_PERIPH
) (
   // gated clocks from the control block
   input wire pcgr_pkg::pcgr_gclk_t gclk_in,
   // pulse counts per slot
   output int sys_cnt_out [NUM_PERIPH],
   output int hs_cnt_out [NUM_PERIPH],
   output int ls_cnt_out [NUM_PERIPH]
);
   for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_slot
      initial begin
         sys_cnt_out[i] = 0;
         hs_cnt_out[i] = 0;
         ls_cnt_out[i] = 0;
      end
      always @(posedge gclk_in.sys[i]) sys_cnt_out[i] <= sys_cnt_out[i] + 1;
      always @(posedge gclk_in.hs[i]) hs_cnt_out[i] <= hs_cnt_out[i] + 1;
      always @(posedge gclk_in.ls[i]) ls_cnt_out[i] <= ls_cnt_out[i] + 1;
   end
endmodule

// *** tb/test_pcgr_ctl.sv ***
// self-checking bench for pcgr_ctl against a register model
// assumes the single-cycle register port and clock gates described for pcgr_ctl
`timescale 1ns/100ps
module test_pcgr_ctl;
   localparam logic [15:0] MASK [4] = '{pcgr_pkg::PCGR_MASK_0, pcgr_pkg::PCGR_MASK_1,
      pcgr_pkg::PCGR_MASK_2, pcgr_pkg::PCGR_MASK_3};
   logic clk_in = 1'b0;
   logic hs_clk = 1'b0;
   logic ls_clk = 1'b0;
   logic resetn_in = 1'b0;
   pcgr_pkg::pcgr_bus_req_t bus_req = '0;
   logic [15:0] rdata;
   logic [17:0] stop;
   logic [17:0] hold;
   pcgr_pkg::pcgr_gclk_t gclk;
   int sys_cnt [18];
   int hs_cnt [18];
   int ls_cnt [18];
   int n_fail = 0;
   int cmp_count = 0;
   logic [15:0] mreg [8];
   logic [31:0] lfsr = 32'hFFEA;
   logic pend = 1'b0;
   logic [15:0] pend_exp;

   initial forever #25 clk_in = ~clk_in;
   // side clocks run unrelated in phase to the system clock
   initial forever #15 hs_clk = ~hs_clk;
   initial forever #55 ls_clk = ~ls_clk;

   pcgr_ctl u_pcgr_ctl (.clk_in(clk_in), .hs_clk_in(hs_clk), .ls_clk_in(ls_clk), .resetn_in(resetn_in),
      .bus_req_in(bus_req), .bus_rdata_out(rdata), .clk_stop_out(stop), .rst_hold_out(hold), .gclk_out(gclk));
   pcgr_periph_model u_pcgr_periph_model (.gclk_in(gclk), .sys_cnt_out(sys_cnt), .hs_cnt_out(hs_cnt),
      .ls_cnt_out(ls_cnt));

   // ==========================================================
   // model and helpers
   function automatic logic [17:0] vec(input int b);
      return {mreg[b+3][6:0], mreg[b+2][13], mreg[b+2][5:4], mreg[b+1][12], mreg[b+1][5:0], mreg[b][0]};
   endfunction

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic reset_dut();
      @(posedge clk_in);
      resetn_in <= 1'b0;
      bus_req <= '0;
      repeat (8) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      foreach (mreg[i]) mreg[i] = 16'h0000;
      pend = 1'b0;
   endtask

   // one bus cycle; the previous read's answer is checked in this cycle
   task automatic op(input logic w, input logic r, input logic [15:0] a, input logic wd, input logic [15:0] d);
      logic ok;
      logic [15:0] cur;
      @(posedge clk_in);
      bus_req <= '{addr: a, wdata: d, word: wd, wr: w, rd: r};
      #1;
      if (pend) check("read data", {16'h0000, rdata}, {16'h0000, pend_exp});
      check("clock stop", {14'h0000, stop}, {14'h0000, vec(0)});
      check("reset hold", {14'h0000, hold}, {14'h0000, vec(4)});
      ok = a[15:4] == pcgr_pkg::PCGR_GATE0_ADDR[15:4] && !(wd && a[0]);
      cur = ok ? mreg[a[3:1]] : 16'h0000;
      pend = r;
      pend_exp = !ok ? 16'h0000 : wd ? cur : a[0] ? {8'h00, cur[15:8]} : {8'h00, cur[7:0]};
      if (w && ok) mreg[a[3:1]] = (wd ? d : a[0] ? {d[7:0], cur[7:0]} : {cur[15:8], d[7:0]}) & MASK[a[2:1]];
   endtask

   // stopped slots must see no pulse on any of the three clocks, running ones must
   task automatic gate_check();
      int s0 [18];
      int h0 [18];
      int l0 [18];
      logic [17:0] st;
      op(1'b0, 1'b0, 16'h0000, 1'b0, 16'h0000);
      st = vec(0);
      repeat (30) @(posedge clk_in);
      s0 = sys_cnt;
      h0 = hs_cnt;
      l0 = ls_cnt;
      repeat (40) @(posedge clk_in);
      for (int i = 0; i < 18; i++) begin
         check("pulses", {29'h0, sys_cnt[i] != s0[i], hs_cnt[i] != h0[i], ls_cnt[i] != l0[i]},
            {29'h0, {3{!st[i]}}});
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (20000) @(posedge clk_in);
      n_fail++;
      conclude();
   end

   initial begin
      reset_dut();
      gate_check();
      for (int a = 16'hF06E; a < 16'hF082; a++) begin
         op(1'b0, 1'b1, a[15:0], 1'b0, 16'h0000);
         op(1'b0, 1'b1, a[15:0], 1'b1, 16'h0000);
      end
      for (int a = 16'hF06E; a < 16'hF082; a += 2) begin
         op(1'b1, 1'b0, a[15:0], 1'b1, 16'hFFFF);
         op(1'b0, 1'b1, a[15:0], 1'b1, 16'h0000);
      end
      op(1'b0, 1'b1, 16'hF073, 1'b0, 16'h0000);
      gate_check();
      // a byte write to every lane, each followed by a word read at the same address, which is dropped for odd lanes
      for (int a = 16'hF06E; a < 16'hF082; a++) begin
         lfsr = lfsr_next(lfsr);
         op(1'b1, 1'b0, a[15:0], 1'b0, lfsr[15:0]);
         op(1'b0, 1'b1, a[15:0], 1'b1, 16'h0000);
      end
      for (int n = 0; n < 300; n++) begin
         lfsr = lfsr_next(lfsr);
         op(lfsr[5], !lfsr[5], 16'hF06E + 16'(lfsr[4:0]), lfsr[6], lfsr[31:16]);
      end
      gate_check();
      reset_dut();
      gate_check();
      op(1'b0, 1'b1, 16'hF07A, 1'b1, 16'h0000);
      op(1'b0, 1'b0, 16'h0000, 1'b0, 16'h0000);
      conclude();
   end
endmodule
